// file: design/otg_cfg_pkg.sv
// Constants, types and state layout of the supply and PHY configuration block
// Operation
// - Supply-valid change events count only while the A-side input is high.
// - Both supply-valid edge enables clear disables it; status bit 1 reads 0.
// - External indicator is constant one; its selection logic resets disabled.
// - Receive-command supply-valid follows external-use, passthrough and invert selection.
// - OTG control bit 3 drives the supply discharge path.
// - OTG control bit 4 drives the supply charge path.
// - Entering serial mode loads the regulator level from the IO register field.
// - In serial mode receive commands carry no line state on bits 1:0.
// - Charger pull-ups are 0 in reset, else follow their IO register bits.
// - Strap inputs are latched at power-up and at every reset release.
// - Strap 00/01/10/11 selects 13, 19.2, 26 and 24 MHz.
// - End of receive is signalled within 43 high-speed clocks.
// - Link commands steer to the transmitter or the register array.
// - Direction is high while owning the bus and rises when not ready or a receive-command change is seen in idle; else low.
// - Each direction change gives one undriven, ignored turnaround cycle.
package otg_cfg_pkg;
   // ------------------------------------------------------------
   // Register offsets and fields
   // ------------------------------------------------------------
   localparam logic [3:0] A_OTG_CTRL = 4'h0;
   localparam logic [3:0] A_EN_RISE = 4'h1;
   localparam logic [3:0] A_EN_FALL = 4'h2;
   localparam logic [3:0] A_STATUS = 4'h3;
   localparam logic [3:0] A_IO_PWR = 4'h4;
   localparam logic [3:0] A_EXT_IND = 4'h5;
   localparam logic [3:0] A_IRQ_STAT = 4'h6;
   localparam logic [3:0] A_IRQ_MASK = 4'h7;
   localparam logic [3:0] A_STRAP = 4'h8;
   localparam int B_DISCHARGE = 3;
   localparam int B_CHARGE = 4;
   localparam int B_SUPPLY = 1;
   localparam int B_SESSION = 2;
   localparam int B_PU_POS = 0;
   localparam int B_PU_NEG = 1;
   localparam int B_LEVEL = 2;
   localparam int B_SERIAL = 4;
   localparam int B_EXT_USE = 0;
   localparam int B_EXT_PASS = 1;
   localparam int B_EXT_INV = 2;
   localparam int I_SUPPLY = 0;
   localparam int I_SESSION = 1;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RST_EXT = 3'h0;
   // ------------------------------------------------------------
   // Timing and encodings
   // ------------------------------------------------------------
   localparam int RX_END_HS_CLKS = 43;
   localparam int HS_MHZ = 480;
   localparam int CLK_MHZ = 250;
   localparam int RX_END_CYC = (RX_END_HS_CLKS * CLK_MHZ) / HS_MHZ;
   localparam logic [14:0] F_13 = 15'h32C8;
   localparam logic [14:0] F_19 = 15'h4B00;
   localparam logic [14:0] F_26 = 15'h6590;
   localparam logic [14:0] F_24 = 15'h5DC0;
   localparam logic [1:0] VB_VALID = 2'h3;
   localparam logic [1:0] VB_SESS = 2'h2;
   localparam logic [1:0] VB_LOW = 2'h0;
   localparam logic [1:0] CMD_TX = 2'h1;
   localparam logic [1:0] CMD_WR = 2'h2;
   localparam logic [1:0] CMD_RD = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LINK = 3'b001,
      ST_TURN_UP = 3'b010,
      ST_PHY = 3'b011,
      ST_TURN_DN = 3'b100
   } phy_state_e;

   typedef struct packed {
      phy_state_e st;
      logic [7:0] otg_ctrl, en_rise, en_fall, io_pwr, rdata, cmd, data_out, tx_byte, reg_data;
      logic [2:0] ext_ind;
      logic [1:0] irq_stat, irq_mask, strap, sv_sync, ss_sync, reg_level, ls_sent, vb_sent;
      logic strap_done, sv_q, ss_q, serial_q, rx_busy, rx_end, dir, nxt, data_oe;
      logic tx_valid, reg_wr, reg_rd, irq;
      logic [5:0] reg_addr;
      logic [4:0] rx_cnt;
      logic [14:0] freq_khz;
   } state_s;
endpackage

// file: design/otg_vbus_and_phy_config.sv
// Supply-valid selection, supply pulsing, charger pull-ups, straps and ULPI steering
`timescale 1ns/10ps
module otg_vbus_and_phy_config (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic irq,
   input wire logic supply_valid_cmp,
   input wire logic session_valid_cmp,
   input wire logic a_side,
   input wire logic [1:0] line_state,
   input wire logic [1:0] refclk_freq_strap,
   input wire logic hs_rx_done,
   output logic rx_end,
   output logic supply_discharge_ctl,
   output logic supply_charge_ctl,
   output logic charger_pullup_en_pos,
   output logic charger_pullup_en_neg,
   output logic [1:0] serial_mode_regulator_level,
   output logic [1:0] refclk_sel,
   output logic [14:0] refclk_khz,
   input wire logic not_ready,
   input wire logic [7:0] ulpi_data_in,
   output logic [7:0] ulpi_data_out,
   output logic ulpi_data_oe,
   output logic ulpi_dir,
   output logic ulpi_nxt,
   input wire logic ulpi_stp,
   output logic tx_valid,
   output logic [7:0] tx_byte,
   output logic array_wr,
   output logic array_rd,
   output logic [5:0] array_addr,
   output logic [7:0] array_wdata
);
   otg_cfg_pkg::state_s s;
   otg_cfg_pkg::state_s next_s;
   logic sv_en;
   logic sv_eff;
   logic rep_sv;
   logic [1:0] vb_code;
   logic [1:0] ls_code;
   logic [7:0] rxcmd;
   logic change;
   logic [1:0] ev;

   // ------------------------------------------------------------
   // Status derivation
   // ------------------------------------------------------------
   always_comb begin
      sv_en = s.en_rise[otg_cfg_pkg::B_SUPPLY] | s.en_fall[otg_cfg_pkg::B_SUPPLY];
      sv_eff = sv_en & s.sv_sync[1];
      // External indicator is a constant one, so passthrough reduces to invert
      if (!s.ext_ind[otg_cfg_pkg::B_EXT_USE]) begin
         rep_sv = sv_eff;
      end else if (s.ext_ind[otg_cfg_pkg::B_EXT_PASS]) begin
         rep_sv = ~s.ext_ind[otg_cfg_pkg::B_EXT_INV];
      end else begin
         rep_sv = s.ext_ind[otg_cfg_pkg::B_EXT_INV] ? 1'b0 : sv_eff;
      end
      if (rep_sv) begin
         vb_code = otg_cfg_pkg::VB_VALID;
      end else if (s.ss_sync[1]) begin
         vb_code = otg_cfg_pkg::VB_SESS;
      end else begin
         vb_code = otg_cfg_pkg::VB_LOW;
      end
      ls_code = s.io_pwr[otg_cfg_pkg::B_SERIAL] ? 2'h0 : line_state;
      rxcmd = {4'h0, vb_code, ls_code};
      change = (vb_code != s.vb_sent) || (ls_code != s.ls_sent);
      ev[otg_cfg_pkg::I_SUPPLY] = a_side & sv_en & (s.sv_sync[1] != s.sv_q);
      ev[otg_cfg_pkg::I_SESSION] = s.ss_sync[1] != s.ss_q;
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.tx_valid = 1'b0;
      next_s.reg_wr = 1'b0;
      next_s.reg_rd = 1'b0;
      next_s.rx_end = 1'b0;
      // Only the second stage is read by anything else
      next_s.sv_sync = {s.sv_sync[0], supply_valid_cmp};
      next_s.ss_sync = {s.ss_sync[0], session_valid_cmp};
      next_s.sv_q = s.sv_sync[1];
      next_s.ss_q = s.ss_sync[1];
      if (!s.strap_done) begin
         next_s.strap_done = 1'b1;
         next_s.strap = refclk_freq_strap;
         case (refclk_freq_strap)
            2'h0: next_s.freq_khz = otg_cfg_pkg::F_13;
            2'h1: next_s.freq_khz = otg_cfg_pkg::F_19;
            2'h2: next_s.freq_khz = otg_cfg_pkg::F_26;
            default: next_s.freq_khz = otg_cfg_pkg::F_24;
         endcase
      end
      next_s.serial_q = s.io_pwr[otg_cfg_pkg::B_SERIAL];
      if (s.io_pwr[otg_cfg_pkg::B_SERIAL] && !s.serial_q) begin
         next_s.reg_level = s.io_pwr[otg_cfg_pkg::B_LEVEL +: 2];
      end
      // Fixed delay stands in for the receive pipeline; stays under the limit
      if (hs_rx_done && !s.rx_busy) begin
         next_s.rx_busy = 1'b1;
         next_s.rx_cnt = 5'(otg_cfg_pkg::RX_END_CYC - 1);
      end else if (s.rx_busy) begin
         next_s.rx_cnt = s.rx_cnt - 5'h1;
         if (s.rx_cnt == 5'h1) begin
            next_s.rx_busy = 1'b0;
            next_s.rx_end = 1'b1;
         end
      end
      // Register port
      next_s.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            otg_cfg_pkg::A_OTG_CTRL: next_s.rdata = s.otg_ctrl;
            otg_cfg_pkg::A_EN_RISE: next_s.rdata = s.en_rise;
            otg_cfg_pkg::A_EN_FALL: next_s.rdata = s.en_fall;
            otg_cfg_pkg::A_STATUS: next_s.rdata = {5'h0, s.ss_sync[1], sv_eff, 1'b0};
            otg_cfg_pkg::A_IO_PWR: next_s.rdata = s.io_pwr;
            otg_cfg_pkg::A_EXT_IND: next_s.rdata = {5'h0, s.ext_ind};
            otg_cfg_pkg::A_IRQ_STAT: next_s.rdata = {6'h0, s.irq_stat};
            otg_cfg_pkg::A_IRQ_MASK: next_s.rdata = {6'h0, s.irq_mask};
            otg_cfg_pkg::A_STRAP: next_s.rdata = {6'h0, s.strap};
            default: next_s.rdata = 8'h00;
         endcase
      end
      next_s.irq_stat = s.irq_stat;
      if (reg_wr) begin
         case (reg_addr)
            otg_cfg_pkg::A_OTG_CTRL: next_s.otg_ctrl = reg_wdata;
            otg_cfg_pkg::A_EN_RISE: next_s.en_rise = reg_wdata;
            otg_cfg_pkg::A_EN_FALL: next_s.en_fall = reg_wdata;
            otg_cfg_pkg::A_IO_PWR: next_s.io_pwr = reg_wdata;
            otg_cfg_pkg::A_EXT_IND: next_s.ext_ind = reg_wdata[2:0];
            otg_cfg_pkg::A_IRQ_STAT: next_s.irq_stat = s.irq_stat & ~reg_wdata[1:0];
            otg_cfg_pkg::A_IRQ_MASK: next_s.irq_mask = reg_wdata[1:0];
            default: next_s.irq_stat = s.irq_stat;
         endcase
      end
      // Set beats clear in the same cycle
      next_s.irq_stat = next_s.irq_stat | ev;
      next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
      // ULPI side
      case (s.st)
         otg_cfg_pkg::ST_IDLE: begin
            if (not_ready || change) begin
               next_s.st = otg_cfg_pkg::ST_TURN_UP;
               next_s.dir = 1'b1;
               next_s.data_oe = 1'b0;
            end else if (ulpi_data_in != 8'h00) begin
               next_s.cmd = ulpi_data_in;
               next_s.reg_addr = ulpi_data_in[5:0];
               if (ulpi_data_in[7:6] == otg_cfg_pkg::CMD_RD) begin
                  next_s.reg_rd = 1'b1;
               end else begin
                  next_s.st = otg_cfg_pkg::ST_LINK;
                  next_s.nxt = 1'b1;
               end
            end
         end
         otg_cfg_pkg::ST_LINK: begin
            if (ulpi_stp) begin
               next_s.st = otg_cfg_pkg::ST_IDLE;
               next_s.nxt = 1'b0;
            end else if (s.cmd[7:6] == otg_cfg_pkg::CMD_TX) begin
               next_s.tx_valid = 1'b1;
               next_s.tx_byte = ulpi_data_in;
            end else if (s.cmd[7:6] == otg_cfg_pkg::CMD_WR) begin
               next_s.reg_wr = 1'b1;
               next_s.reg_data = ulpi_data_in;
            end
         end
         otg_cfg_pkg::ST_TURN_UP: begin
            // Bus is not sampled while it turns
            next_s.st = otg_cfg_pkg::ST_PHY;
            next_s.data_oe = 1'b1;
            next_s.data_out = rxcmd;
            next_s.vb_sent = vb_code;
            next_s.ls_sent = ls_code;
         end
         otg_cfg_pkg::ST_PHY: begin
            next_s.data_out = rxcmd;
            next_s.vb_sent = vb_code;
            next_s.ls_sent = ls_code;
            if (!not_ready) begin
               next_s.st = otg_cfg_pkg::ST_TURN_DN;
               next_s.dir = 1'b0;
               next_s.data_oe = 1'b0;
            end
         end
         otg_cfg_pkg::ST_TURN_DN: next_s.st = otg_cfg_pkg::ST_IDLE;
         default: begin
            next_s.st = otg_cfg_pkg::ST_IDLE;
            next_s.dir = 1'b0;
            next_s.data_oe = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
         s.st <= otg_cfg_pkg::ST_IDLE;
         s.otg_ctrl <= otg_cfg_pkg::RST_BYTE;
         s.io_pwr <= otg_cfg_pkg::RST_BYTE;
         s.ext_ind <= otg_cfg_pkg::RST_EXT;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.rdata;
   assign irq = s.irq;
   assign rx_end = s.rx_end;
   assign supply_discharge_ctl = s.otg_ctrl[otg_cfg_pkg::B_DISCHARGE];
   assign supply_charge_ctl = s.otg_ctrl[otg_cfg_pkg::B_CHARGE];
   assign charger_pullup_en_pos = s.io_pwr[otg_cfg_pkg::B_PU_POS];
   assign charger_pullup_en_neg = s.io_pwr[otg_cfg_pkg::B_PU_NEG];
   assign serial_mode_regulator_level = s.reg_level;
   assign refclk_sel = s.strap;
   assign refclk_khz = s.freq_khz;
   assign ulpi_data_out = s.data_out;
   assign ulpi_data_oe = s.data_oe;
   assign ulpi_dir = s.dir;
   assign ulpi_nxt = s.nxt;
   assign tx_valid = s.tx_valid;
   assign tx_byte = s.tx_byte;
   assign array_wr = s.reg_wr;
   assign array_rd = s.reg_rd;
   assign array_addr = s.reg_addr;
   assign array_wdata = s.reg_data;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   localparam int rx_bound = otg_cfg_pkg::RX_END_CYC;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b || !clk_en);

   discharge_on_a: assert property (
      reg_wr && reg_addr == otg_cfg_pkg::A_OTG_CTRL |=> supply_discharge_ctl == $past(reg_wdata[3]))
      else $error("discharge control does not follow its bit");
   charge_on_a: assert property (
      reg_wr && reg_addr == otg_cfg_pkg::A_OTG_CTRL |=> supply_charge_ctl == $past(reg_wdata[4]))
      else $error("charge control does not follow its bit");
   status_off_a: assert property (
      reg_rd && !reg_wr && reg_addr == otg_cfg_pkg::A_STATUS && !sv_en |=> !reg_rdata[1])
      else $error("disabled supply valid reads one");
   fixed_one_a: assert property (
      ulpi_data_oe && $past(s.ext_ind) == 3'h3 |-> ulpi_data_out[3:2] == otg_cfg_pkg::VB_VALID)
      else $error("passthrough did not report fixed one");
   fixed_zero_a: assert property (
      ulpi_data_oe && $past(s.ext_ind[0]) && $past(s.ext_ind[2])
      |-> ulpi_data_out[3:2] != otg_cfg_pkg::VB_VALID)
      else $error("invert did not report fixed zero");
   turnaround_a: assert property ($changed(ulpi_dir) |-> !ulpi_data_oe)
      else $error("bus driven in turnaround");
   pullup_follow_a: assert property (
      reg_wr && reg_addr == otg_cfg_pkg::A_IO_PWR |=> charger_pullup_en_pos == $past(reg_wdata[0]))
      else $error("pull-up does not follow its bit");
   rx_latency_a: assert property (
      hs_rx_done && !s.rx_busy |-> ##[1:rx_bound] rx_end)
      else $error("receive end too late");
   serial_level_a: assert property (
      $rose(s.io_pwr[4]) |=> serial_mode_regulator_level == $past(s.io_pwr[3:2]))
      else $error("regulator level not loaded on serial entry");
   serial_ls_a: assert property (
      ulpi_data_oe && $past(s.io_pwr[4]) |-> ulpi_data_out[1:0] == 2'h0)
      else $error("line state shown in serial mode");
   strap_latch_a: assert property (
      $rose(s.strap_done) |-> refclk_sel == $past(refclk_freq_strap))
      else $error("strap not latched");
   tx_steer_a: assert property (
      s.st == otg_cfg_pkg::ST_LINK && !ulpi_stp && s.cmd[7:6] == otg_cfg_pkg::CMD_TX
      |=> tx_valid && tx_byte == $past(ulpi_data_in))
      else $error("transmit byte not steered");
   dir_busy_a: assert property (
      not_ready && s.st == otg_cfg_pkg::ST_IDLE |=> ulpi_dir)
      else $error("direction low while not ready");

   rxcmd_c: cover property (s.st == otg_cfg_pkg::ST_PHY ##1 s.st == otg_cfg_pkg::ST_TURN_DN);
   array_wr_c: cover property (array_wr);
   serial_c: cover property ($rose(s.io_pwr[4]));
   irq_c: cover property ($rose(irq));
endmodule // otg_vbus_and_phy_config

// file: sim/link_model.sv
// Behavioural link controller on the ULPI side of the block
`timescale 1ns/10ps
module link_model (
   input wire logic ref_clk,
   input wire logic ulpi_dir,
   input wire logic ulpi_nxt,
   output wire logic [7:0] ulpi_data_in,
   output logic ulpi_stp
);
   logic [7:0] drv;
   logic [7:0] last;
   logic dir_q;
   logic own;
   // Bus is ours only with dir low and no turnaround pending
   assign own = !ulpi_dir && !dir_q;
   // Released bus shows the inverse, never a stale byte
   assign ulpi_data_in = own ? drv : ~last;
   initial begin
      drv = 8'h00;
      last = 8'h00;
      dir_q = 1'b0;
      ulpi_stp = 1'b0;
   end
   always @(posedge ref_clk) begin
      dir_q <= ulpi_dir;
      if (own) last <= drv;
   end
   // ----------------------------------------
   // Command, then one byte and a stop unless it is a read
   // ----------------------------------------
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat);
      int n;
      n = 0;
      // Mid-cycle look, so dir and own are settled
      @(negedge ref_clk);
      while (!own && n < 50) begin
         @(negedge ref_clk);
         n++;
      end
      @(posedge ref_clk);
      drv <= cmd;
      // Command taken here; the byte must stand at the next edge
      @(posedge ref_clk);
      if (cmd[7:6] != 2'b11) begin
         drv <= dat;
         @(negedge ref_clk);
         while (!ulpi_nxt && n < 60) begin
            @(negedge ref_clk);
            n++;
         end
         @(posedge ref_clk);
         ulpi_stp <= 1'b1;
      end
      drv <= 8'h00;
      @(posedge ref_clk);
      ulpi_stp <= 1'b0;
   endtask
endmodule // link_model

// file: sim/tb_otg_vbus_and_phy_config.sv
// Self-checking bench for the supply and PHY configuration block
`timescale 1ns/10ps
module tb_otg_vbus_and_phy_config;
   logic ref_clk, rst_b, reg_wr, reg_rd, sv, ss, a_side, hs_done, not_ready, clk_en;
   logic irq, rx_end, dis, chg, pup, pun, oe, dir, nxt, stp, txv, awr, ard;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, dout, d, din, txb, awd, got_tx;
   logic [1:0] ls, strap, lvl, sel;
   logic [13:0] got_wr;
   logic [5:0] got_rd, aaddr;
   logic [14:0] khz;
   int failures, total_checks, tx_cnt, nxt_cnt;

   otg_vbus_and_phy_config dut (
      .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(addr), .reg_wdata(wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .irq(irq), .supply_valid_cmp(sv),
      .session_valid_cmp(ss), .a_side(a_side), .line_state(ls), .refclk_freq_strap(strap),
      .hs_rx_done(hs_done), .rx_end(rx_end), .supply_discharge_ctl(dis),
      .supply_charge_ctl(chg), .charger_pullup_en_pos(pup), .charger_pullup_en_neg(pun),
      .serial_mode_regulator_level(lvl), .refclk_sel(sel), .refclk_khz(khz),
      .not_ready(not_ready), .ulpi_data_in(din), .ulpi_data_out(dout), .ulpi_data_oe(oe),
      .ulpi_dir(dir), .ulpi_nxt(nxt), .ulpi_stp(stp), .tx_valid(txv), .tx_byte(txb),
      .array_wr(awr), .array_rd(ard), .array_addr(aaddr), .array_wdata(awd));
   link_model link (.ref_clk(ref_clk), .ulpi_dir(dir), .ulpi_nxt(nxt), .ulpi_data_in(din),
      .ulpi_stp(stp));

   always @(posedge ref_clk) begin
      if (txv === 1'b1) got_tx <= txb;
      if (awr === 1'b1) got_wr <= {aaddr, awd};
      if (ard === 1'b1) got_rd <= aaddr;
      if (txv === 1'b1) tx_cnt <= tx_cnt + 1;
      if (nxt === 1'b1) nxt_cnt <= nxt_cnt + 1;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = rdata;
   endtask
   function automatic logic [1:0] vb_exp(input logic c, input logic [2:0] e);
      logic r;
      if (!e[0]) r = c;
      else if (e[1]) r = ~e[2];
      else r = c & ~e[2];
      return r ? 2'b11 : 2'b10;
   endfunction
   // Status byte forced out by holding not_ready
   task automatic rxcmd(input logic [7:0] exp);
      int n;
      n = 0;
      cyc(6);
      not_ready <= 1'b1;
      while (dir !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         #1 n++;
      end
      check(oe, 1'b0);
      @(posedge ref_clk);
      #1 check({dir, oe}, 2'b11);
      check(dout, exp);
      @(posedge ref_clk);
      not_ready <= 1'b0;
      cyc(4);
      #1 check(dir, 1'b0);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_straps();
      logic [14:0] fk [4];
      fk = '{15'h32C8, 15'h4B00, 15'h6590, 15'h5DC0};
      for (int s = 0; s < 4; s++) begin
         strap <= s[1:0];
         wr(otg_cfg_pkg::A_IO_PWR, 8'h03);
         #1 check({pun, pup}, 2'b11);
         @(posedge ref_clk);
         rst_b <= 1'b0;
         #1 check({pun, pup}, 2'b00);
         cyc(2);
         rst_b <= 1'b1;
         cyc(2);
         strap <= ~s[1:0];
         cyc(2);
         #1 check(sel, s[1:0]);
         check(khz, fk[s]);
         rd(otg_cfg_pkg::A_EXT_IND);
         check(d, 8'h00);
      end
      rd(4'hF);
      check(d, 8'h00);
      $display("done: straps");
   endtask
   task automatic t_supply();
      logic [7:0] v [4];
      v = '{8'h08, 8'h10, 8'h18, 8'h00};
      foreach (v[i]) begin
         wr(otg_cfg_pkg::A_OTG_CTRL, v[i]);
         #1 check(dis, v[i][3]);
         check(chg, v[i][4]);
      end
      // Frozen block must ignore a write
      @(posedge ref_clk);
      clk_en <= 1'b0;
      wr(otg_cfg_pkg::A_OTG_CTRL, 8'h08);
      #1 check(dis, 1'b0);
      @(posedge ref_clk);
      clk_en <= 1'b1;
      $display("done: supply");
   endtask
   task automatic t_status();
      @(posedge ref_clk);
      sv <= 1'b1;
      ss <= 1'b1;
      cyc(8);
      wr(otg_cfg_pkg::A_EN_RISE, 8'h02);
      wr(otg_cfg_pkg::A_EN_FALL, 8'h02);
      rd(otg_cfg_pkg::A_STATUS);
      check(d, 8'h06);
      wr(otg_cfg_pkg::A_EN_RISE, 8'h00);
      rd(otg_cfg_pkg::A_STATUS);
      check(d, 8'h06);
      wr(otg_cfg_pkg::A_EN_FALL, 8'h00);
      rd(otg_cfg_pkg::A_STATUS);
      check(d, 8'h04);
      check(d[2], 1'b1);
      wr(otg_cfg_pkg::A_EN_RISE, 8'h02);
      wr(otg_cfg_pkg::A_EN_FALL, 8'h02);
      $display("done: status");
   endtask
   task automatic t_irq();
      wr(otg_cfg_pkg::A_IRQ_MASK, 8'h00);
      wr(otg_cfg_pkg::A_IRQ_STAT, 8'h03);
      @(posedge ref_clk);
      a_side <= 1'b0;
      sv <= 1'b0;
      cyc(8);
      rd(otg_cfg_pkg::A_IRQ_STAT);
      check(d, 8'h00);
      @(posedge ref_clk);
      a_side <= 1'b1;
      sv <= 1'b1;
      cyc(8);
      rd(otg_cfg_pkg::A_IRQ_STAT);
      check(d, 8'h01);
      check(irq, 1'b0);
      wr(otg_cfg_pkg::A_IRQ_MASK, 8'h01);
      cyc(2);
      #1 check(irq, 1'b1);
      wr(otg_cfg_pkg::A_IRQ_STAT, 8'h01);
      cyc(2);
      #1 check(irq, 1'b0);
      $display("done: irq");
   endtask
   task automatic t_table();
      for (int s = 0; s < 2; s++) begin
         @(posedge ref_clk);
         sv <= s[0];
         cyc(10);
         for (int e = 0; e < 8; e++) begin
            wr(otg_cfg_pkg::A_EXT_IND, 8'(e));
            rxcmd({4'h0, vb_exp(s[0], e[2:0]), 2'b01});
         end
      end
      wr(otg_cfg_pkg::A_EXT_IND, 8'h00);
      $display("done: table");
   endtask
   task automatic t_serial();
      wr(otg_cfg_pkg::A_IO_PWR, 8'h1C);
      cyc(2);
      #1 check(lvl, 2'b11);
      rxcmd(8'h0C);
      wr(otg_cfg_pkg::A_IO_PWR, 8'h00);
      rxcmd(8'h0D);
      wr(otg_cfg_pkg::A_IO_PWR, 8'h14);
      cyc(2);
      #1 check(lvl, 2'b01);
      wr(otg_cfg_pkg::A_IO_PWR, 8'h00);
      $display("done: serial");
   endtask
   task automatic t_rx_end();
      int n;
      n = 0;
      @(posedge ref_clk);
      hs_done <= 1'b1;
      @(posedge ref_clk);
      hs_done <= 1'b0;
      while (rx_end !== 1'b1 && n < 40) begin
         @(posedge ref_clk);
         #1 n++;
      end
      // Latency counted from the edge taking the pulse to the edge seeing rx_end
      check(16'(n + 1), 16'(otg_cfg_pkg::RX_END_CYC));
      check((n + 1) * 480 <= 43 * 250, 1'b1);
      $display("done: rx_end");
   endtask
   task automatic t_ulpi();
      link.xfer(8'h41, 8'hA5);
      cyc(3);
      check(got_tx, 8'hA5);
      check(16'(tx_cnt), 16'h0001);
      check(16'(nxt_cnt), 16'h0002);
      link.xfer(8'h85, 8'h3C);
      cyc(3);
      check(got_wr, {6'h05, 8'h3C});
      check(16'(nxt_cnt), 16'h0004);
      link.xfer(8'hC7, 8'h00);
      cyc(3);
      check(got_rd, 6'h07);
      check(16'(nxt_cnt), 16'h0004);
      $display("done: ulpi");
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ----------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // Run needs well under 1k cycles; limit is near 25k
   initial begin
      #100000;
      failures++;
      finish_test();
   end
   initial begin
      {rst_b, reg_wr, reg_rd, sv, ss, a_side, hs_done, not_ready} = 8'h00;
      clk_en = 1'b1;
      tx_cnt = 0;
      nxt_cnt = 0;
      addr = 4'h0;
      wdata = 8'h00;
      ls = 2'b01;
      strap = 2'b00;
      {got_tx, got_wr, got_rd} = 28'h0000000;
      failures = 0;
      total_checks = 0;
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_straps();
      t_supply();
      t_status();
      t_irq();
      t_table();
      t_serial();
      t_rx_end();
      t_ulpi();
      finish_test();
   end
endmodule // tb_otg_vbus_and_phy_config
